// ===== hdl/tmr_cc_pkg.sv
// shared constants and carriers for the channel 3 register d capture/compare control
// assumes a single clk_sys domain at 100 MHz with asynchronous active-high reset
package tmr_cc_pkg;

    localparam int          COUNTER_W          = 16;
    localparam logic [3:0]  IO_CTRL_RESET      = 4'h0;
    localparam logic [2:0]  PRESCALE_UNDIVIDED = 3'h0;
    localparam logic [15:0] GENREG_RESET       = 16'hffff;
    localparam logic        PIN_RESET          = 1'b0;
    localparam int          SYNC_STAGES        = 3;

    // what the pin does on a compare match
    typedef enum logic [1:0]
    {
        MATCH_NONE   = 2'h0,
        MATCH_LOW    = 2'h1,
        MATCH_HIGH   = 2'h2,
        MATCH_TOGGLE = 2'h3
    } match_act_t;

    // decoded role of the io control field
    typedef struct packed
    {
        logic       compareOn;
        logic       initLevel;
        match_act_t matchAct;
        logic       captureOn;
        logic       capRise;
        logic       capFall;
        logic       capCounter;
    } io_role_t;

    // channel 4 counter count events
    typedef struct packed
    {
        logic countUp;
        logic countDown;
    } ch4_count_t;

endpackage : tmr_cc_pkg

// ===== hdl/pin_edge_sync.sv
// three-stage synchroniser for the capture/compare pin with edge detection
// assumes the pin is asynchronous to clk_sys; stage one feeds only stage two
`timescale 1ns/1ps
module pin_edge_sync
(
    input  wire logic clk_sys,
    input  wire logic reset,
    input  wire logic clkEn,
    input  wire logic pinIn,
    output logic      riseSeen,
    output logic      fallSeen
);
    logic [tmr_cc_pkg::SYNC_STAGES-1:0] stage;
    logic [tmr_cc_pkg::SYNC_STAGES-1:0] next_stage;
    logic                               level;
    logic                               next_level;
    logic                               agree;

    // shift the pin through the chain; accept a level once stages two and three agree
    always_comb
    begin
        next_stage = {stage[tmr_cc_pkg::SYNC_STAGES-2:0], pinIn};
        agree      = stage[1] == stage[2];
        next_level = agree ? stage[2] : level;
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            stage <= '0;
            level <= 1'b0;
        end
        else if (clkEn)
        begin
            stage <= next_stage;
            level <= next_level;
        end
    end

    // an edge counts once stages two and three agree on a level other than the accepted one
    assign riseSeen = clkEn & agree & stage[2] & ~level;
    assign fallSeen = clkEn & agree & ~stage[2] & level;

endmodule : pin_edge_sync

// ===== hdl/ch3_reg_d_cc_ctl.sv
// capture/compare control for the fourth general register of timer channel 3
// assumes counter and count events come from logic on clk_sys; the pin is asynchronous
`timescale 1ns/1ps
// What this block does
// RL1 - Codes 0000/0100 disable the pin, 0001-0011 start low then drive 0/1/toggle, 0101/0110 start high then drive 0/1.
// RL2 - Code 0111 is output compare starting high and toggling on each match.
// RL3 - Code 1000 captures on a rising pin edge.
// RL4 - Code 1001 captures on a falling pin edge.
// RL5 - Code 101x captures on both pin edges.
// RL6 - Code 11xx captures on each channel 4 count-up or count-down.
// RL7 - With channel 4 prescaler select at 000 no channel 4 sourced capture occurs.
// RL8 - With buffer mode set, neither capture nor compare happens.
// RL9 - A valid capture copies the channel 3 counter into the register in the trigger cycle.
module ch3_reg_d_cc_ctl
#(
    parameter int COUNTER_W = tmr_cc_pkg::COUNTER_W
)
(
    input  wire logic                   clk_sys,
    input  wire logic                   reset,
    input  wire logic                   clkEn,
    input  wire logic [3:0]             reg_d_io_control_field,
    input  wire logic                   reg_d_buffer_mode,
    input  wire logic [2:0]             ch4_prescaler_select,
    input  wire tmr_cc_pkg::ch4_count_t ch4CountEvt,
    input  wire logic [COUNTER_W-1:0]   ch3Counter,
    input  wire logic                   compareMatch,
    input  wire logic                   regWrite,
    input  wire logic [COUNTER_W-1:0]   regWriteData,
    input  wire logic                   ch3_capture_compare_pin_d_in,
    output logic                        ch3_capture_compare_pin_d_out,
    output logic                        ch3_capture_compare_pin_d_oe_n,
    output logic [COUNTER_W-1:0]        ch3_general_register_d,
    output logic                        captureEvent
);
    tmr_cc_pkg::io_role_t role;
    logic                 riseSeen;
    logic                 fallSeen;
    logic                 capTrig;
    logic [3:0]           ioPrev;
    logic                 bufPrev;
    logic                 next_pinOut;
    logic                 next_pinOeN;
    logic [COUNTER_W-1:0] next_genReg;
    logic                 next_capEvt;

    // pin synchroniser and edge finder
    pin_edge_sync u_sync
    (
        .clk_sys  (clk_sys),
        .reset    (reset),
        .clkEn    (clkEn),
        .pinIn    (ch3_capture_compare_pin_d_in),
        .riseSeen (riseSeen),
        .fallSeen (fallSeen)
    );

    // decode the io control field into a role
    always_comb
    begin
        role = '0;
        role.matchAct = tmr_cc_pkg::MATCH_NONE;
        unique case (reg_d_io_control_field[3:2])
            2'h0, 2'h1:
            begin
                // RL1 compare code table
                role.compareOn = reg_d_io_control_field[1:0] != 2'h0;
                role.initLevel = reg_d_io_control_field[2];
                role.matchAct  = tmr_cc_pkg::match_act_t'(reg_d_io_control_field[1:0]);
                // RL2 start high toggle
                if (reg_d_io_control_field == 4'h7)
                    role.matchAct = tmr_cc_pkg::MATCH_TOGGLE;
            end
            2'h2:
            begin
                role.captureOn = 1'b1;
                // RL3 rising edge
                role.capRise   = ~reg_d_io_control_field[1] & ~reg_d_io_control_field[0]
                                 | reg_d_io_control_field[1];
                // RL4 RL5 falling and both
                role.capFall   = reg_d_io_control_field[0] | reg_d_io_control_field[1];
            end
            2'h3:
            begin
                // RL6 counter source
                role.captureOn  = 1'b1;
                role.capCounter = 1'b1;
            end
        endcase
    end

    // capture trigger gated by buffer mode and undivided clock
    always_comb
    begin
        capTrig = 1'b0;
        if (role.captureOn && !reg_d_buffer_mode)
        begin
            if (role.capCounter)
                // RL7 undivided prescaler blocks
                capTrig = clkEn && (ch4_prescaler_select != tmr_cc_pkg::PRESCALE_UNDIVIDED)
                          && (ch4CountEvt.countUp || ch4CountEvt.countDown);
            else
                capTrig = (role.capRise && riseSeen) || (role.capFall && fallSeen);
        end
    end

    // next pin, register and event values
    always_comb
    begin
        next_pinOut = ch3_capture_compare_pin_d_out;
        next_pinOeN = 1'b1;
        next_genReg = ch3_general_register_d;
        next_capEvt = 1'b0;
        // RL8 buffer mode idles the pin
        if (role.compareOn && !reg_d_buffer_mode)
        begin
            next_pinOeN = 1'b0;
            if (ioPrev != reg_d_io_control_field || bufPrev)
                next_pinOut = role.initLevel;  // initial level on new setting
            else if (compareMatch)
            begin
                unique case (role.matchAct)
                    tmr_cc_pkg::MATCH_LOW:    next_pinOut = 1'b0;
                    tmr_cc_pkg::MATCH_HIGH:   next_pinOut = 1'b1;
                    tmr_cc_pkg::MATCH_TOGGLE: next_pinOut = ~ch3_capture_compare_pin_d_out;
                    tmr_cc_pkg::MATCH_NONE:   next_pinOut = ch3_capture_compare_pin_d_out;
                endcase
            end
        end
        if (regWrite)
            next_genReg = regWriteData;
        // RL9 capture wins over write
        if (capTrig)
        begin
            next_genReg = ch3Counter;
            next_capEvt = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            ch3_capture_compare_pin_d_out  <= tmr_cc_pkg::PIN_RESET;
            ch3_capture_compare_pin_d_oe_n <= 1'b1;
            ch3_general_register_d         <= COUNTER_W'(tmr_cc_pkg::GENREG_RESET);
            captureEvent                   <= 1'b0;
            ioPrev                         <= tmr_cc_pkg::IO_CTRL_RESET;
            bufPrev                        <= 1'b0;
        end
        else if (clkEn)
        begin
            ch3_capture_compare_pin_d_out  <= next_pinOut;
            ch3_capture_compare_pin_d_oe_n <= next_pinOeN;
            ch3_general_register_d         <= next_genReg;
            captureEvent                   <= next_capEvt;
            ioPrev                         <= reg_d_io_control_field;
            bufPrev                        <= reg_d_buffer_mode;
        end
    end

    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    chk_disabled_pin_off: assert property ( // RL1
        clkEn && (reg_d_io_control_field[1:0] == 2'h0) && !reg_d_io_control_field[3]
        |=> ch3_capture_compare_pin_d_oe_n)
        else $error("pin driven while output disabled");
    chk_toggle_on_match: assert property ( // RL2
        clkEn && reg_d_io_control_field == 4'h7 && $stable(reg_d_io_control_field)
        && !reg_d_buffer_mode && !bufPrev && ioPrev == 4'h7 && compareMatch
        |=> ch3_capture_compare_pin_d_out != $past(ch3_capture_compare_pin_d_out))
        else $error("pin did not toggle on match");
    chk_rise_capture: assert property ( // RL3
        clkEn && reg_d_io_control_field == 4'h8 && !reg_d_buffer_mode && riseSeen
        |=> captureEvent && ch3_general_register_d == $past(ch3Counter))
        else $error("rising edge missed");
    chk_fall_capture: assert property ( // RL4
        clkEn && reg_d_io_control_field == 4'h9 && !reg_d_buffer_mode && fallSeen
        |=> captureEvent)
        else $error("falling edge missed");
    chk_rise_no_fall: assert property ( // RL3
        clkEn && reg_d_io_control_field == 4'h8 && !riseSeen |=> !captureEvent)
        else $error("capture without rising edge");
    chk_both_edges: assert property ( // RL5
        clkEn && reg_d_io_control_field[3:1] == 3'h5 && !reg_d_buffer_mode
        && (riseSeen || fallSeen) |=> captureEvent)
        else $error("edge missed in both mode");
    chk_count_capture: assert property ( // RL6
        clkEn && reg_d_io_control_field[3:2] == 2'h3 && !reg_d_buffer_mode
        && ch4_prescaler_select != 3'h0 && ch4CountEvt.countDown |=> captureEvent)
        else $error("count event missed");
    chk_undivided_block: assert property ( // RL7
        clkEn && reg_d_io_control_field[3:2] == 2'h3 && ch4_prescaler_select == 3'h0
        |=> !captureEvent)
        else $error("capture with undivided clock");
    chk_buffer_block: assert property ( // RL8
        clkEn && reg_d_buffer_mode |=> !captureEvent && ch3_capture_compare_pin_d_oe_n)
        else $error("activity in buffer mode");
    chk_capture_value: assert property ( // RL9
        captureEvent && $past(clkEn) |-> ch3_general_register_d == $past(ch3Counter))
        else $error("captured value wrong");
    chk_low_start: assert property ( // RL1
        clkEn && reg_d_io_control_field[3:2] == 2'h0 && reg_d_io_control_field[1:0] != 2'h0
        && ioPrev != reg_d_io_control_field && !reg_d_buffer_mode
        |=> !ch3_capture_compare_pin_d_out && !ch3_capture_compare_pin_d_oe_n)
        else $error("wrong start level for low codes");
    chk_high_start: assert property ( // RL1 RL2
        clkEn && reg_d_io_control_field[3:2] == 2'h1 && reg_d_io_control_field[1:0] != 2'h0
        && ioPrev != reg_d_io_control_field && !reg_d_buffer_mode
        |=> ch3_capture_compare_pin_d_out && !ch3_capture_compare_pin_d_oe_n)
        else $error("wrong start level for high codes");
    chk_buffer_hold: assert property ( // RL8
        clkEn && reg_d_buffer_mode && compareMatch
        |=> ch3_capture_compare_pin_d_out == $past(ch3_capture_compare_pin_d_out))
        else $error("pin moved on match in buffer mode");
    chk_count_up: assert property ( // RL6
        clkEn && reg_d_io_control_field[3:2] == 2'h3 && !reg_d_buffer_mode
        && ch4_prescaler_select != 3'h0 && ch4CountEvt.countUp |=> captureEvent)
        else $error("count-up event missed");
    chk_freeze_state: assert property ( // clock enable low holds state
        !clkEn |=> $stable(ch3_general_register_d) && $stable(captureEvent)
        && $stable(ch3_capture_compare_pin_d_out) && $stable(ch3_capture_compare_pin_d_oe_n))
        else $error("state moved while clock enable low");

    cov_rise: cover property (captureEvent && reg_d_io_control_field == 4'h8);
    cov_count: cover property (captureEvent && reg_d_io_control_field[3:2] == 2'h3);
    cov_toggle: cover property (compareMatch && reg_d_io_control_field == 4'h7);
    cov_both: cover property (captureEvent && reg_d_io_control_field[3:1] == 3'h5);
    cov_buffered: cover property (compareMatch && reg_d_buffer_mode);

endmodule : ch3_reg_d_cc_ctl

// ===== verif/pin_partner.sv
// pin model: external driver on the channel 3 register d pin
// assumes the design owns the wire while its enable is low
`timescale 1ns/1ps
module pin_partner
(
    input  wire logic pinOut,
    input  wire logic pinOeN,
    output logic      pinWire
);
    logic extLevel = 1'b0;
    // resolved wire: design when enabled, else this driver
    assign pinWire = pinOeN ? extLevel : pinOut;
    // change level after a skew, prompt or slow
    task automatic setLevel(input logic v, input int skew);
        #(skew);
        extLevel = v;
    endtask : setLevel
endmodule : pin_partner

// ===== verif/ch3_reg_d_cc_ctl_bench.sv
// bench for the register d capture/compare control
// assumes clk_sys at 100 MHz; pin_partner drives the pin when released
`timescale 1ns/1ps
module ch3_reg_d_cc_ctl_bench;
    logic                   clk_sys = 1'b0;
    logic                   reset = 1'b1;
    logic                   clkEn = 1'b1;
    logic [3:0]             ioField = 4'h0;
    logic                   bufMode = 1'b0;
    logic [2:0]             prescale = 3'h1;
    tmr_cc_pkg::ch4_count_t cntEvt = '0;
    logic [15:0]            ch3Counter = 16'h0;
    logic                   compareMatch = 1'b0;
    logic                   regWrite = 1'b0;
    logic [15:0]            wrData = 16'h0;
    logic                   pinWire, pinOut, pinOeN, capEvt;
    logic [15:0]            genReg;
    int                     errors = 0;
    int                     compares = 0;
    int                     code;
    // {initial, first match, second match} levels per compare code
    localparam logic [2:0] CMP_TAB [8] = '{3'h0, 3'h0, 3'h3, 3'h2, 3'h0, 3'h4, 3'h7, 3'h5};

    // clock and free-running channel 3 counter
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) ch3Counter <= #1 ch3Counter + 16'h1;

    ch3_reg_d_cc_ctl dut
    (
        .clk_sys(clk_sys), .reset(reset), .clkEn(clkEn),
        .reg_d_io_control_field(ioField), .reg_d_buffer_mode(bufMode),
        .ch4_prescaler_select(prescale), .ch4CountEvt(cntEvt), .ch3Counter(ch3Counter),
        .compareMatch(compareMatch), .regWrite(regWrite), .regWriteData(wrData),
        .ch3_capture_compare_pin_d_in(pinWire), .ch3_capture_compare_pin_d_out(pinOut),
        .ch3_capture_compare_pin_d_oe_n(pinOeN), .ch3_general_register_d(genReg),
        .captureEvent(capEvt)
    );
    pin_partner partner (.pinOut(pinOut), .pinOeN(pinOeN), .pinWire(pinWire));

    task automatic tick();
        @(posedge clk_sys);
        #1;
    endtask : tick
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        compares++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic checkBit(input logic seen, input logic exp, input string what);
        check({15'h0, seen}, {15'h0, exp}, what);
    endtask : checkBit
    task automatic matchPulse();
        tick();
        compareMatch = 1'b1;
        tick();
        compareMatch = 1'b0;
        tick();
    endtask : matchPulse
    task automatic pulseEvt(input logic up, input logic down);
        tick();
        cntEvt.countUp = up;
        cntEvt.countDown = down;
    endtask : pulseEvt
    // watch eight cycles; a capture must hold the count of its trigger edge
    task automatic waitCap(input logic exp, input string what);
        logic seen;
        seen = 1'b0;
        for (int n = 0; n < 8; n++)
        begin
            tick();
            cntEvt = '0;
            #1;
            if (capEvt === 1'b1 && !seen)
            begin
                seen = 1'b1;
                check(genReg, ch3Counter - 16'h1, what);
            end
        end
        checkBit(seen, exp, what);
        tick();
    endtask : waitCap
    task automatic complete_run();
        if (errors == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : complete_run

    // main sequence: reset, compare codes, capture codes, blocked cases
    initial
    begin
        repeat (6) tick();
        checkBit(pinOeN, 1'b1, "reset enable");
        checkBit(pinOut, tmr_cc_pkg::PIN_RESET, "reset pin");
        check(genReg, tmr_cc_pkg::GENREG_RESET, "reset register");
        reset = 1'b0;
        for (code = 0; code < 8; code++)
        begin
            ioField = code[3:0];
            repeat (3) tick();
            checkBit(pinOeN, code[1:0] == 2'h0, "pin enable");
            if (code[1:0] != 2'h0)
            begin
                checkBit(pinOut, CMP_TAB[code][2], "initial level");
                matchPulse();
                checkBit(pinOut, CMP_TAB[code][1], "first match");
                matchPulse();
                checkBit(pinOut, CMP_TAB[code][0], "second match");
            end
        end
        ioField = 4'h0;
        wrData = 16'h1234;
        regWrite = 1'b1;
        tick();
        regWrite = 1'b0;
        repeat (5) tick();
        check(genReg, 16'h1234, "register write");
        for (code = 8; code < 16; code++)
        begin
            ioField = code[3:0];
            repeat (3) tick();
            checkBit(pinOeN, 1'b1, "capture enable");
            partner.setLevel(1'b1, 0);
            waitCap(code[3:2] == 2'h2 && code != 9, "rise");
            partner.setLevel(1'b0, 0);
            waitCap(code[3:2] == 2'h2 && code != 8, "fall");
            pulseEvt(1'b1, 1'b0);
            waitCap(code[3:2] == 2'h3, "count up");
            pulseEvt(1'b0, 1'b1);
            waitCap(code[3:2] == 2'h3, "count down");
        end
        prescale = 3'h0;
        repeat (2) tick();
        pulseEvt(1'b1, 1'b0);
        waitCap(1'b0, "undivided source");
        prescale = 3'h1;
        clkEn = 1'b0;
        pulseEvt(1'b1, 1'b0);
        waitCap(1'b0, "frozen count");
        clkEn = 1'b1;
        bufMode = 1'b1;
        ioField = 4'ha;
        repeat (3) tick();
        partner.setLevel(1'b1, 0);
        waitCap(1'b0, "buffered rise");
        bufMode = 1'b0;
        ioField = 4'h3;
        repeat (3) tick();
        bufMode = 1'b1;
        matchPulse();
        checkBit(pinOut, 1'b0, "buffered match");
        checkBit(pinOeN, 1'b1, "buffered release");
        complete_run();
    end
endmodule : ch3_reg_d_cc_ctl_bench
